/* File: hw/smr_pkg.sv */
// Package for the supply monitor and pin reset block.
// Assumes an 8-bit special-function-register bus on a 200 MHz clock.
package smr_pkg;

  // Register map
  localparam logic [7:0] SMR_CTRL_ADDR       = 8'hff;
  localparam logic [7:0] SMR_RST_SOURCE_ADDR = 8'hef;

  // Field positions
  localparam int unsigned SMR_EN_BIT       = 7;
  localparam int unsigned SMR_STAT_BIT     = 6;
  localparam int unsigned SMR_PIN_FLAG_BIT = 0;
  localparam int unsigned SMR_POR_FLAG_BIT = 1;

  // Values after reset
  localparam logic        SMR_EN_RST       = 1'b0;
  localparam logic        SMR_SEL_RST      = 1'b0;
  localparam logic        SMR_FLAG_RST     = 1'b0;
  localparam logic [1:0]  SMR_PIN_SYNC_RST = 2'b11;
  localparam logic [1:0]  SMR_MON_SYNC_RST = 2'b00;
  localparam logic [15:0] SMR_CNT_RST      = 16'h0000;
  localparam logic [7:0]  SMR_RDATA_RST    = 8'h00;

  // Timing
  localparam int unsigned SMR_CLK_MHZ       = 200;
  localparam int unsigned SMR_RST_DELAY_US  = 32;
  localparam int unsigned SMR_RST_DELAY_CYC = SMR_RST_DELAY_US * SMR_CLK_MHZ;
  // Edges spent in sync, hold exit and last count, outside the counter load
  localparam int unsigned SMR_DELAY_LAG     = 4;

  // Reset sequencer states
  typedef enum logic [1:0] {
    SMR_ST_RUN   = 2'b00,
    SMR_ST_HOLD  = 2'b01,
    SMR_ST_DELAY = 2'b10
  } smr_state_t;

endpackage : smr_pkg

/* File: hw/smr_top.sv */
// Supply monitor control, reset source selection and pin reset sequencing.
// Assumes a byte-wide register bus and an asynchronous level from the comparator.
//
// Summary of operation
// R01: Top bit of monitor control turns the monitor on or off, read/write.
// R02: Monitor resets the system only when also selected as reset source.
// R03: Software enables monitor, waits turn-on time, then selects it as source.
// R04: Writing one to the power-on flag bit selects the monitor as source.
// R05: Bit six reads the live monitor output, one when supply above threshold.
// R06: Six low control bits read zero and ignore writes.
// R07: After a monitor reset, skip the post-reset delay.
// R08: A low level on the external reset pin requests a reset.
// R09: On leaving a pin reset, set the pin reset flag, bit zero.
// R10: Other resets release code execution within 32 microseconds.
// R11: Synchronise pin and monitor; hold reset while any active source remains.
`timescale 1ns/1ps
module smr_top
  import smr_pkg::*;
#(
  parameter int unsigned DELAY_CYC = SMR_RST_DELAY_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // Register bus
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Analog and pin side
  input  wire logic       supply_above_i,
  input  wire logic       rst_pin_n_i,
  output logic            monitor_en_o,
  // System reset out
  output logic            sys_rst_o
);


  // Counter load; sync, hold exit and last count edges make up the rest of the delay
  localparam logic [15:0] DELAY_LOAD = 16'(DELAY_CYC - SMR_DELAY_LAG);  // [R10]

  // Synchroniser stages
  logic [1:0]  pin_sync;
  logic [1:0]  next_pin_sync;
  logic [1:0]  mon_sync;
  logic [1:0]  next_mon_sync;
  // Software-visible control bits
  logic        supply_monitor_enable;
  logic        next_supply_monitor_enable;
  logic        monitor_selected;
  logic        next_monitor_selected;
  // Reset cause flags
  logic        pin_reset_flag;
  logic        next_pin_reset_flag;
  logic        mon_reset_flag;
  logic        next_mon_reset_flag;
  // Reset sequencer
  smr_state_t  state;
  smr_state_t  next_state;
  logic [15:0] delay_cnt;
  logic [15:0] next_delay_cnt;
  logic        last_pin;
  logic        next_last_pin;
  // Registered read data
  logic [7:0]  reg_rdata;
  logic [7:0]  next_reg_rdata;
  // Decoded selects and requests
  logic        ctrl_sel;
  logic        rst_source_sel;
  logic        wr_allowed;
  logic        pin_req;
  logic        mon_req;
  logic        any_req;

  // Address decode
  always_comb begin
    ctrl_sel       = 1'b0;
    rst_source_sel = 1'b0;
    if (reg_addr_i == SMR_CTRL_ADDR) begin
      ctrl_sel = 1'b1;
    end else if (reg_addr_i == SMR_RST_SOURCE_ADDR) begin
      rst_source_sel = 1'b1;
    end
  end

  // Requests from synchronised levels; writes refused while in reset
  always_comb begin
    wr_allowed = reg_wr_i & (state == SMR_ST_RUN);
    pin_req    = ~pin_sync[1];                                         // [R08]
    mon_req    = supply_monitor_enable & monitor_selected & ~mon_sync[1];  // [R02]
    any_req    = pin_req | mon_req;                                    // [R11]
  end

  // Synchroniser next values; only the second stage is read elsewhere
  always_comb begin
    next_pin_sync = {pin_sync[0], rst_pin_n_i};     // [R11]
    next_mon_sync = {mon_sync[0], supply_above_i};  // [R11]
  end

  // Synchroniser registers; pin stage presets to its idle high level
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_sync <= SMR_PIN_SYNC_RST;
      mon_sync <= SMR_MON_SYNC_RST;
    end else begin
      pin_sync <= next_pin_sync;
      mon_sync <= next_mon_sync;
    end
  end

  // Control bit next values; reserved bits of the write are dropped
  always_comb begin
    next_supply_monitor_enable = supply_monitor_enable;
    next_monitor_selected      = monitor_selected;
    if (wr_allowed && ctrl_sel) begin
      next_supply_monitor_enable = reg_wdata_i[SMR_EN_BIT];   // [R01] [R06]
    end else if (wr_allowed && rst_source_sel) begin
      next_monitor_selected = reg_wdata_i[SMR_POR_FLAG_BIT];  // [R04]
    end
  end

  // Control bit registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      supply_monitor_enable <= SMR_EN_RST;
      monitor_selected      <= SMR_SEL_RST;
    end else begin
      supply_monitor_enable <= next_supply_monitor_enable;
      monitor_selected      <= next_monitor_selected;
    end
  end

  // Reset sequencer and cause flags, updated on reset exit
  always_comb begin
    next_state          = state;
    next_delay_cnt      = delay_cnt;
    next_last_pin       = last_pin;
    next_pin_reset_flag = pin_reset_flag;
    next_mon_reset_flag = mon_reset_flag;
    case (state)
      SMR_ST_RUN: begin
        if (any_req) begin
          next_state    = SMR_ST_HOLD;
          next_last_pin = pin_req;
        end
      end
      SMR_ST_HOLD: begin
        if (any_req) begin                        // [R11]
          next_last_pin = pin_req;                // Last source to drop wins
        end else begin
          next_pin_reset_flag = last_pin;         // [R09]
          next_mon_reset_flag = ~last_pin;
          if (last_pin) begin
            next_state     = SMR_ST_DELAY;
            next_delay_cnt = DELAY_LOAD;          // [R10]
          end else begin
            next_state = SMR_ST_RUN;              // [R07]
          end
        end
      end
      SMR_ST_DELAY: begin
        if (any_req) begin
          next_state    = SMR_ST_HOLD;            // New request restarts hold
          next_last_pin = pin_req;
        end else if (delay_cnt == 16'h0000) begin
          next_state = SMR_ST_RUN;                // [R10]
        end else begin
          next_delay_cnt = delay_cnt - 16'h0001;
        end
      end
      default: begin
        next_state = SMR_ST_HOLD;
      end
    endcase
  end

  // Sequencer and flag registers; reset enters hold
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state          <= SMR_ST_HOLD;
      delay_cnt      <= SMR_CNT_RST;
      last_pin       <= SMR_FLAG_RST;
      pin_reset_flag <= SMR_FLAG_RST;
      mon_reset_flag <= SMR_FLAG_RST;
    end else begin
      state          <= next_state;
      delay_cnt      <= next_delay_cnt;
      last_pin       <= next_last_pin;
      pin_reset_flag <= next_pin_reset_flag;
      mon_reset_flag <= next_mon_reset_flag;
    end
  end

  // Read data next value; reserved and unmapped bits read zero
  always_comb begin
    next_reg_rdata = SMR_RDATA_RST;                                      // [R06]
    if (ctrl_sel) begin
      next_reg_rdata[SMR_EN_BIT]   = supply_monitor_enable;              // [R01]
      next_reg_rdata[SMR_STAT_BIT] = mon_sync[1];                        // [R05]
    end else if (rst_source_sel) begin
      next_reg_rdata[SMR_PIN_FLAG_BIT] = pin_reset_flag;                 // [R09]
      next_reg_rdata[SMR_POR_FLAG_BIT] = monitor_selected | mon_reset_flag;  // [R04]
    end
  end

  // Read data register, one cycle behind the address
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata <= SMR_RDATA_RST;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Outputs
  assign reg_rdata_o  = reg_rdata;
  assign monitor_en_o = supply_monitor_enable;
  assign sys_rst_o    = (state != SMR_ST_RUN);   // [R11]

endmodule : smr_top

/* File: tb/smr_pin_model.sv */
// Model of the external reset circuit on the pin.
// Assumes a pull-up holds the pin high when idle.
`timescale 1ns/1ps
module smr_pin_model #(parameter int unsigned LOW_CYC = 3000) (
  // Clock and request
  input  wire logic clk_i,
  input  wire logic go_i,
  // Pin
  output logic      rst_pin_n_o
);
  int unsigned cnt = 0;
  // Hold the pin low for the minimum low time
  always @(posedge clk_i)
    if (go_i) cnt <= LOW_CYC;
    else if (cnt > 0) cnt <= cnt - 1;
  assign rst_pin_n_o = (cnt == 0);  // Low level asks for reset
endmodule : smr_pin_model

/* File: tb/smr_sva.sv */
// Checker for the supply monitor and pin reset top.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module smr_sva
  import smr_pkg::*;
#(parameter int unsigned DELAY_CYC = 8) (
  // Watched ports
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic       reg_wr_i,
  input wire logic       supply_above_i,
  input wire logic       rst_pin_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       monitor_en_o,
  input wire logic       sys_rst_o
);
  localparam int DMAX = DELAY_CYC + 6;
  localparam int PMAX = DELAY_CYC - 2;
  logic [15:0] hi;
  // Cycles since the pin was last low
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i) hi <= 16'hffff;
    else hi <= rst_pin_n_i ? hi + 16'(hi != 16'hffff) : 16'h0000;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_rsvd_zero: assert property ($past(reg_addr_i) == SMR_CTRL_ADDR |->
    reg_rdata_o[5:0] == 6'h00) else $error("reserved");
  a_en_read: assert property ($past(reg_addr_i) == SMR_CTRL_ADDR &&
    $stable(monitor_en_o) |-> reg_rdata_o[7] == monitor_en_o) else $error("enable read");
  a_en_write: assert property (reg_wr_i && !sys_rst_o && reg_addr_i == SMR_CTRL_ADDR
    |=> monitor_en_o == $past(reg_wdata_i[7])) else $error("enable write");
  a_stat_live: assert property ((reg_addr_i == SMR_CTRL_ADDR && !sys_rst_o
    && $stable(supply_above_i))[*4] |=> reg_rdata_o[6] == $past(supply_above_i))
    else $error("status");
  a_pin_hold: assert property (!rst_pin_n_i [*4] |-> sys_rst_o) else $error("pin");
  a_rst_cause: assert property ($rose(sys_rst_o) |-> monitor_en_o || hi < 16'h0005)
    else $error("cause");
  a_pin_delay: assert property ($rose(rst_pin_n_i) && sys_rst_o |->
    sys_rst_o [*3] ##[1:PMAX] !sys_rst_o) else $error("pin delay");
  a_mon_fast: assert property ($rose(supply_above_i) && sys_rst_o && hi > DMAX |->
    ##[1:4] !sys_rst_o) else $error("monitor delay");
  c_mon: cover property ($rose(sys_rst_o) && rst_pin_n_i);
  c_pin: cover property ($rose(sys_rst_o) && !rst_pin_n_i);
  c_wr: cover property (reg_wr_i && reg_addr_i == SMR_CTRL_ADDR);
endmodule : smr_sva
bind smr_top smr_sva #(.DELAY_CYC(DELAY_CYC)) u_sva (.*);

/* File: tb/tb.sv */
// Bench for the supply monitor and pin reset block.
// Assumes the checker bind and pin model are compiled first.
`timescale 1ns/1ps
module tb;
  import smr_pkg::*;
  localparam int DLY = 8;
  logic       clk_i, arst_n_i, reg_wr_i, supply_above_i, rst_pin_n_i, go;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic       monitor_en_o, sys_rst_o;
  int         miscompares = 0, checks = 0, n;
  smr_top #(.DELAY_CYC(DLY)) uut (.*);
  smr_pin_model pin (.clk_i(clk_i), .go_i(go), .rst_pin_n_o(rst_pin_n_i));
  // Clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #300000;
    miscompares++;
    final_report;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge clk_i) reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_i) reg_addr_i <= a;
    @(posedge clk_i) #1 chk(reg_rdata_o & m, e);
  endtask : rd
  task automatic wait_rst(input logic v);
    for (n = 0; sys_rst_o !== v && n < 9000; n++) @(posedge clk_i) #1;
    chk(8'(n < 9000), 8'h01);
  endtask : wait_rst
  task final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    {arst_n_i, reg_wr_i, supply_above_i, go} = 4'b0010;
    {reg_addr_i, reg_wdata_i} = 16'h0000;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    wait_rst(1'b0);
    rd(SMR_CTRL_ADDR, 8'hff, {SMR_EN_RST, 7'h40});
    rd(SMR_RST_SOURCE_ADDR, 8'h03, 8'h02);
    wr(SMR_CTRL_ADDR, 8'hbf);
    wr(8'hfe, 8'h00);
    chk({7'h00, monitor_en_o}, 8'h01);
    rd(SMR_CTRL_ADDR, 8'hff, 8'hc0);
    @(posedge clk_i) supply_above_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rd(SMR_CTRL_ADDR, 8'hff, 8'h80);
    chk({7'h00, sys_rst_o}, 8'h00);
    @(posedge clk_i) supply_above_i <= 1'b1;
    repeat (20000) @(posedge clk_i);  // Turn-on wait before selecting
    wr(SMR_RST_SOURCE_ADDR, 8'h02);
    @(posedge clk_i) supply_above_i <= 1'b0;
    wait_rst(1'b1);
    chk(8'(n < 5), 8'h01);
    @(posedge clk_i) supply_above_i <= 1'b1;
    wait_rst(1'b0);
    chk(8'(n < DLY), 8'h01);
    @(posedge clk_i) go <= 1'b1;
    @(posedge clk_i) go <= 1'b0;
    wait_rst(1'b1);
    chk(8'(n < 5), 8'h01);
    wait (rst_pin_n_i === 1'b1);
    wait_rst(1'b0);
    chk(8'(n >= DLY - 2 && n <= DLY), 8'h01);
    rd(SMR_RST_SOURCE_ADDR, 8'h03, 8'h03);
    final_report;
  end
endmodule : tb
